// >>> inc/smbad_pkg.sv
// Shared constants for the management-bus address decoder.
// Assumes both ends and the bench import this package.
package smbad_pkg;

  // ----------------------------------------
  // Address word layout
  // ----------------------------------------
  localparam int unsigned ADDR_W   = 7;  // Address bits 7..1
  localparam int unsigned BYTE_W   = 8;  // Address word width
  localparam int unsigned NIB_W    = 4;  // Upper nibble width
  localparam int unsigned SEL_W    = 3;  // Low select field width

  // Upper nibble patterns
  localparam logic [3:0] NIB_MEM   = 4'ha;  // Serial memory group
  localparam logic [3:0] NIB_TS_LO = 4'h3;  // Sensor, strap low
  localparam logic [3:0] NIB_TS_FL = 4'h5;  // Sensor, strap floating
  localparam logic [3:0] NIB_TS_HI = 4'h9;  // Sensor, strap high
  localparam logic [3:0] NIB_RSVD  = 4'h0;  // Reserved range

  // Select-field bases per sensor group
  localparam logic [2:0] BASE_LO   = 3'h0;
  localparam logic [2:0] BASE_FL   = 3'h1;
  localparam logic [2:0] BASE_HI   = 3'h4;

  // ----------------------------------------
  // Tri-level strap code
  // ----------------------------------------
  localparam logic [1:0] TRI_LOW   = 2'h0;  // Pulled low
  localparam logic [1:0] TRI_FLOAT = 2'h1;  // Left open
  localparam logic [1:0] TRI_HIGH  = 2'h2;  // Pulled high

  // ----------------------------------------
  // Reset values and link timing
  // ----------------------------------------
  localparam logic [6:0] ADDR_RST  = 7'h00;  // Held address at reset
  localparam logic [3:0] ACK_BIT   = 4'h8;   // Index of ack bit
  localparam logic [3:0] DONE_BIT  = 4'h9;   // Past the ack bit
  localparam int unsigned HALF_DIV = 4;      // Core cycles per half bit

  // Sensor address from the two held straps
  function automatic logic [6:0] smbad_ts_addr(input logic [1:0] lo,
                                               input logic [1:0] hi);
    logic [3:0] nib;
    logic [2:0] base;
    logic [2:0] step;
    nib  = (lo == TRI_LOW) ? NIB_TS_LO : (lo == TRI_HIGH) ? NIB_TS_HI : NIB_TS_FL;
    base = (lo == TRI_LOW) ? BASE_LO : (lo == TRI_HIGH) ? BASE_HI : BASE_FL;
    step = (hi == TRI_LOW) ? 3'h0 : (hi == TRI_HIGH) ? 3'h2 : 3'h1;
    return {nib, 3'(base + step)};
  endfunction : smbad_ts_addr

endpackage : smbad_pkg

// >>> inc/smbad_link_if.sv
// Serial link between the bus host and the decoding device.
// Assumes the bench ties both modports; data line is open drain
// with a pull-up worked out here from the two enables.
`timescale 1ns/1ps
interface smbad_link_if;
  logic scl;            // Link clock, made by the host
  logic frame_n;        // Low while a transfer is open
  logic host_sda_o;     // Host data drive value
  logic host_sda_oe_n;  // Host drives data when low
  logic dev_sda_o;      // Device data drive value
  logic dev_sda_oe_n;   // Device drives data when low
  logic sda;            // Resolved data line level

  // Wired-AND with pull-up
  assign sda = ~((~host_sda_oe_n & ~host_sda_o) | (~dev_sda_oe_n & ~dev_sda_o));

  modport host (output scl, frame_n, host_sda_o, host_sda_oe_n, input sda);
  modport dev  (input scl, frame_n, sda, output dev_sda_o, dev_sda_oe_n);
endinterface : smbad_link_if

// >>> rtl/smbad_host.sv
// Bus host end: sends one address word per non-reserved request, reads the ack.
// Assumes requests from core logic; link clock made here by divider.
`timescale 1ns/1ps
module smbad_host #(
  parameter int unsigned HALF = smbad_pkg::HALF_DIV  // Cycles per half bit
) (
  // Clock and reset
  input  wire logic                       core_clk_i,
  input  wire logic                       nrst_i,
  // Request side
  input  wire logic                       req_valid_i,
  input  wire logic [smbad_pkg::ADDR_W-1:0] req_addr_i,
  input  wire logic                       req_rw_i,
  output logic                            req_ready_o,
  output logic                            done_o,
  output logic                            acked_o,
  output logic                            refused_o,
  // Link
  smbad_link_if.host                      link
);
  import smbad_pkg::*;

  // Ack is read through two flops inside one half bit, and the
  // divider is eight bits wide
  if (HALF < 4 || HALF > 256) begin : g_half_chk
    $error("HALF must lie in 4..256");
  end

  // ----------------------------------------
  // State and registers
  // ----------------------------------------
  typedef enum logic [1:0] {
    H_IDLE = 2'b00, H_OPEN = 2'b01, H_BITS = 2'b11, H_CLOSE = 2'b10
  } smbad_hst_t;

  smbad_hst_t  state;      // Transfer phase
  logic [7:0]  div;        // Half-bit divider
  logic [3:0]  bitn;       // Bit index 0..8
  logic [7:0]  sh;         // Outgoing word
  logic        scl;        // Link clock out
  logic        frame_n;    // Frame out
  logic        sda_oe_n;   // Host data enable, low drives
  logic        sda_m;      // Data line sync, first stage
  logic        sda_s;      // Data line sync, second stage
  logic        ack_seen;   // Line seen low at the ack clock edge

  wire half_end = (div == 8'(HALF - 1));                 // Half bit done
  wire rsvd     = (req_addr_i[6:3] == NIB_RSVD);         // Reserved range
  wire take     = (state == H_IDLE) & req_valid_i;       // Request taken

  // Data line from the other end, two flops
  always_ff @(posedge core_clk_i) begin
    sda_m <= link.sda;
    sda_s <= sda_m;
  end

  // Divider runs only inside a transfer
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i || state == H_IDLE || half_end) begin
      div <= 8'h00;
    end else begin
      div <= div + 8'h01;
    end
  end

  // Transfer sequencer
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      state     <= H_IDLE;
      bitn      <= 4'h0;
      sh        <= 8'hff;
      scl       <= 1'b0;
      frame_n   <= 1'b1;
      sda_oe_n  <= 1'b1;
      ack_seen  <= 1'b0;
      done_o    <= 1'b0;
      acked_o   <= 1'b0;
      refused_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state)
        H_IDLE: begin
          if (take && rsvd) begin          // Never sent: reserved range
            done_o    <= 1'b1;
            acked_o   <= 1'b0;
            refused_o <= 1'b1;
          end else if (take) begin
            sh        <= {req_addr_i, req_rw_i};  // Direction in bit 0
            frame_n   <= 1'b0;
            refused_o <= 1'b0;
            bitn      <= 4'h0;
            state     <= H_OPEN;
          end
        end
        H_OPEN: begin                      // First data bit while clock low
          if (half_end) begin
            sda_oe_n <= sh[7];
            state    <= H_BITS;
          end
        end
        H_BITS: begin
          if (half_end && !scl) begin      // Rising edge: other end samples
            scl <= 1'b1;
            // Device lets go at this edge; the synced level still shows it
            if (bitn == ACK_BIT) begin
              ack_seen <= ~sda_s;
            end
          end else if (half_end) begin     // Falling edge: next bit or ack
            scl <= 1'b0;
            if (bitn == ACK_BIT) begin
              acked_o  <= ack_seen;
              sda_oe_n <= 1'b1;
              state    <= H_CLOSE;
            end else begin
              bitn     <= bitn + 4'h1;
              sh       <= {sh[6:0], 1'b1};
              sda_oe_n <= (bitn == 4'h7) ? 1'b1 : sh[6];  // Release for ack
            end
          end
        end
        H_CLOSE: begin
          if (half_end) begin
            frame_n <= 1'b1;
            done_o  <= 1'b1;
            state   <= H_IDLE;
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    req_ready_o <= nrst_i & (state == H_IDLE) & ~take;
  end

  assign link.scl           = scl;
  assign link.frame_n       = frame_n;
  assign link.host_sda_o    = 1'b0;      // Open drain: drive low only
  assign link.host_sda_oe_n = sda_oe_n;

endmodule : smbad_host

// >>> rtl/smbad_dev.sv
// Device end: address recognition for the serial memory and the
// thermal sensor sharing one management bus.
// Assumes straps come from board pins and the link clock is made by
// the host and stands still outside frames.
//
// What this block does
// - Memory claims 1010 nibble with its selects
// - Unconnected memory select reads as zero
// - Sensor answers only 0011, 1001, 0101 groups
// - Sensor straps are three-level, nine addresses
// - Strap low picks group 3x/5x/9x
// - Strap high picks bits 3..1 in group
// - Address bit 0 is direction, not matched
// - Host never sends the 0000 range
// - Sensor straps held at power-up, conversion start
// - Board sets strap levels before power-up
// - Floating strap means pin left open
// - Memory selects map to bits 3..1
`timescale 1ns/1ps
module smbad_dev (
  // Clock and reset
  input  wire logic                        core_clk_i,
  input  wire logic                        nrst_i,
  // Board straps
  input  wire logic [1:0]                  sensor_addr_strap_lo_i,
  input  wire logic [1:0]                  sensor_addr_strap_hi_i,
  input  wire logic [smbad_pkg::SEL_W-1:0] memory_addr_select_i,
  input  wire logic [smbad_pkg::SEL_W-1:0] memory_addr_select_conn_i,
  // Sensor events
  input  wire logic                        conv_start_i,
  // Status
  output logic [smbad_pkg::ADDR_W-1:0]     sensor_addr_o,
  output logic [smbad_pkg::ADDR_W-1:0]     memory_addr_o,
  output logic                             sensor_hit_o,
  output logic                             memory_hit_o,
  output logic                             hit_rw_o,
  // Link
  smbad_link_if.dev                        link
);
  import smbad_pkg::*;

  // ----------------------------------------
  // Pin synchronisers (core domain)
  // ----------------------------------------
  logic [1:0] ts_lo_m, ts_lo_s;     // Sensor strap low, two stages
  logic [1:0] ts_hi_m, ts_hi_s;     // Sensor strap high, two stages
  logic [2:0] ms_m, ms_s;           // Memory select levels
  logic [2:0] mc_m, mc_s;           // Memory select connected flags
  logic       fb_m, fb_s;           // Frame busy from the link

  // Straps and frame are from outside this clock
  always_ff @(posedge core_clk_i) begin
    ts_lo_m <= sensor_addr_strap_lo_i;
    ts_lo_s <= ts_lo_m;
    ts_hi_m <= sensor_addr_strap_hi_i;
    ts_hi_s <= ts_hi_m;
    ms_m    <= memory_addr_select_i;
    ms_s    <= ms_m;
    mc_m    <= memory_addr_select_conn_i;
    mc_s    <= mc_m;
    fb_m    <= ~link.frame_n;
    fb_s    <= fb_m;
  end

  // ----------------------------------------
  // Held addresses (core domain)
  // ----------------------------------------
  logic       pwrup;                // First cycle after reset still owed
  logic       pend;                 // Latch owed, deferred by a frame
  logic [1:0] ts_lo_h, ts_hi_h;     // Held sensor straps

  // Open select pin is pulled weakly to zero
  wire [2:0] mem_sel = ms_s & mc_s;
  // Sampling requested now or earlier
  wire       want    = pwrup | pend | conv_start_i;
  // Held words freeze while a frame is open, so the link reads stable
  // values; a sample requested meanwhile waits for the frame end.
  wire       latch   = want & ~fb_s;
  wire [6:0] ts_addr = smbad_ts_addr(ts_lo_h, ts_hi_h);

  // Request bookkeeping
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      pwrup <= 1'b1;
      pend  <= 1'b0;
    end else begin
      pwrup <= 1'b0;
      pend  <= want & fb_s;
    end
  end

  // Strap hold at power-up and each conversion start
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      ts_lo_h <= TRI_LOW;
      ts_hi_h <= TRI_LOW;
    end else if (latch) begin
      ts_lo_h <= ts_lo_s;
      ts_hi_h <= ts_hi_s;
    end
  end

  // Published addresses, frozen with the straps
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      sensor_addr_o <= ADDR_RST;
      memory_addr_o <= ADDR_RST;
    end else if (!fb_s) begin
      sensor_addr_o <= ts_addr;
      memory_addr_o <= {NIB_MEM, mem_sel};
    end
  end

  // ----------------------------------------
  // Link domain: address shifter
  // ----------------------------------------
  // Frame idle clears everything here; the link clock may stop
  // right after the last bit, so no edge is counted on to end it.
  logic [3:0] bitn;                 // Bits taken this frame
  logic [6:0] sh;                   // Bits taken so far
  logic       ack;                  // Driving ack low
  logic       hit_f;                // Address matched this frame
  logic       ts_f;                 // Match was the sensor
  logic       mem_f;                // Match was the memory
  logic       rw_f;                 // Direction of the match

  wire        idle    = link.frame_n;
  // Host data changes only while the link clock is low, so it is
  // already in this domain and needs no synchroniser.
  wire [7:0]  word    = {sh, link.sda};
  wire        last    = (bitn == 4'h7);
  // Held words cross frozen: core stops updating while frame busy
  wire        ts_nib  = (word[7:4] == NIB_TS_LO) |
                        (word[7:4] == NIB_TS_FL) |
                        (word[7:4] == NIB_TS_HI);
  wire        ts_m    = ts_nib & (word[7:1] == sensor_addr_o);
  wire        mem_m   = (word[7:4] == NIB_MEM) &
                        (word[3:1] == memory_addr_o[2:0]);
  wire        hit     = last & (ts_m | mem_m);

  // Shift in eight bits, then only the ack bit, then nothing
  always_ff @(posedge link.scl or posedge idle) begin
    if (idle) begin
      bitn <= 4'h0;
      sh   <= 7'h00;
      ack  <= 1'b0;
    end else begin
      if (bitn < DONE_BIT) begin
        bitn <= bitn + 4'h1;
      end
      if (bitn < ACK_BIT) begin
        sh <= word[6:0];
      end
      // Ack only on a match, released at the ack bit's clock rise
      ack <= hit;
    end
  end

  // Match flags: set at the direction bit, held to frame end so the
  // core side sees a level long enough to cross
  always_ff @(posedge link.scl or posedge idle) begin
    if (idle) begin
      hit_f <= 1'b0;
      ts_f  <= 1'b0;
      mem_f <= 1'b0;
      rw_f  <= 1'b0;
    end else if (hit) begin
      hit_f <= 1'b1;
      ts_f  <= ts_m;
      mem_f <= mem_m;
      rw_f  <= link.sda;
    end
  end

  assign link.dev_sda_o    = 1'b0;  // Open drain: pulls low only
  assign link.dev_sda_oe_n = ~ack;

  // ----------------------------------------
  // Event crossing back to the core
  // ----------------------------------------
  logic hit_m, hit_s, hit_d;        // Match flag sync and delay

  // Only the flag crosses on two flops; the detail bits beside it
  // settled a full cycle before the second flop rises and hold
  // until the frame closes, so they are read directly
  always_ff @(posedge core_clk_i) begin
    hit_m <= hit_f;
    hit_s <= hit_m;
  end

  wire hit_new = hit_s & ~hit_d;    // First cycle a match is seen

  // One-cycle hit pulses; direction held until the next match
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      hit_d        <= 1'b0;
      sensor_hit_o <= 1'b0;
      memory_hit_o <= 1'b0;
      hit_rw_o     <= 1'b0;
    end else begin
      hit_d        <= hit_s;
      sensor_hit_o <= hit_new & ts_f;
      memory_hit_o <= hit_new & mem_f;
      hit_rw_o     <= hit_new ? rw_f : hit_rw_o;
    end
  end

endmodule : smbad_dev

// >>> verification/smbad_link_asserts.sv
// Link checker: watches the open-drain data line and host clocking.
// Assumes both ends run on one core clock and meet in one interface.
`timescale 1ns/1ps
module smbad_link_asserts #(
  parameter int HALF = 4  // Core cycles per half bit
) (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic nrst_i,
  // Interface signals
  input  wire logic scl,
  input  wire logic frame_n,
  input  wire logic host_sda_oe_n,
  input  wire logic dev_sda_oe_n
);
  localparam int FMIN = 20 * HALF - 2;  // Shortest open frame
  localparam int FMAX = 20 * HALF + 2;  // Longest open frame
  logic [7:0] ack_cnt;                  // Cycles the ack was held

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  // Count ack cycles; a held ack of wrong length shifts the next bit
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i || dev_sda_oe_n) begin
      ack_cnt <= 8'h00;
    end else begin
      ack_cnt <= ack_cnt + 8'h01;
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_scl_idle; frame_n |-> !scl; endproperty
  property p_dev_idle; frame_n |-> dev_sda_oe_n; endproperty
  // Ack starts under the direction bit's high phase; host is off by the low
  property p_ack_slot; !dev_sda_oe_n && !scl |-> host_sda_oe_n; endproperty
  property p_ack_len; $rose(dev_sda_oe_n) |-> ack_cnt == 2 * HALF; endproperty
  property p_lead; $fell(frame_n) |-> !scl [*4]; endproperty
  property p_frame_len; $fell(frame_n) |-> ##[FMIN:FMAX] $rose(frame_n); endproperty
  property p_scl_high; $rose(scl) |-> ##HALF $fell(scl); endproperty
  property p_bit_stable;
    scl && $past(scl) && !frame_n |-> $stable(host_sda_oe_n);
  endproperty
  // Ack may only begin on a link clock rise inside a frame
  property p_ack_start; $fell(dev_sda_oe_n) |-> scl && !frame_n; endproperty

  a_scl_idle: assert property (p_scl_idle)
    else $error("link clock runs outside frame");
  a_dev_idle: assert property (p_dev_idle)
    else $error("device drives outside frame");
  a_ack_slot: assert property (p_ack_slot)
    else $error("ack while host drives");
  a_ack_len: assert property (p_ack_len)
    else $error("ack length wrong");
  a_lead: assert property (p_lead)
    else $error("clock too soon after frame open");
  a_frame_len: assert property (p_frame_len)
    else $error("frame length wrong");
  a_scl_high: assert property (p_scl_high)
    else $error("clock high phase wrong");
  a_bit_stable: assert property (p_bit_stable)
    else $error("data moved while clock high");
  a_ack_start: assert property (p_ack_start)
    else $error("ack began off a clock rise");

  c_ack: cover property ($fell(dev_sda_oe_n));
  c_frame: cover property ($fell(frame_n));
  c_noack: cover property ($rose(frame_n) && ack_cnt == 8'h00);
endmodule : smbad_link_asserts

// >>> verification/smbus_slave_address_decode_tb.sv
// Bench: host and device ends joined by one link interface.
// Assumes one shared core clock; expectations built from the map.
`timescale 1ns/1ps
module smbus_slave_address_decode_tb;
  import smbad_pkg::*;
  localparam int HALF = 4;               // Half bit in core cycles
  logic       core_clk_i = 1'b0;         // Core clock
  logic       nrst_i = 1'b0;             // Reset, active low
  logic       req_valid_i = 1'b0;        // Host request
  logic [6:0] req_addr_i = 7'h00;        // Address bits 7..1
  logic       req_rw_i = 1'b0;           // Direction bit
  logic [1:0] sensor_addr_strap_lo_i = 2'h0;
  logic [1:0] sensor_addr_strap_hi_i = 2'h0;
  logic [2:0] memory_addr_select_i = 3'h5;
  logic [2:0] memory_addr_select_conn_i = 3'h7;
  logic       conv_start_i = 1'b0;       // Conversion start
  logic       req_ready_o, done_o, acked_o, refused_o;
  logic [6:0] sensor_addr_o, memory_addr_o;
  logic       sensor_hit_o, memory_hit_o, hit_rw_o;
  int         error_cnt = 0;             // Mismatches
  int         n_tests = 0;               // Comparisons

  smbad_link_if link_if();
  smbad_host #(.HALF(HALF)) smbad_host_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .req_valid_i(req_valid_i), .req_addr_i(req_addr_i), .req_rw_i(req_rw_i),
    .req_ready_o(req_ready_o), .done_o(done_o), .acked_o(acked_o),
    .refused_o(refused_o), .link(link_if));
  smbad_dev smbad_dev_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .sensor_addr_strap_lo_i(sensor_addr_strap_lo_i),
    .sensor_addr_strap_hi_i(sensor_addr_strap_hi_i),
    .memory_addr_select_i(memory_addr_select_i),
    .memory_addr_select_conn_i(memory_addr_select_conn_i), .conv_start_i(conv_start_i),
    .sensor_addr_o(sensor_addr_o), .memory_addr_o(memory_addr_o),
    .sensor_hit_o(sensor_hit_o), .memory_hit_o(memory_hit_o), .hit_rw_o(hit_rw_o),
    .link(link_if));
  smbad_link_asserts #(.HALF(HALF)) smbad_link_asserts_inst (.core_clk_i(core_clk_i),
    .nrst_i(nrst_i), .scl(link_if.scl), .frame_n(link_if.frame_n),
    .host_sda_oe_n(link_if.host_sda_oe_n), .dev_sda_oe_n(link_if.dev_sda_oe_n));

  // Core clock, 8 ns
  always #4 core_clk_i = ~core_clk_i;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  // Inputs move 1 ns after the edge, clear of sampling
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : tick

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Expected sensor address: low strap picks group, high strap steps
  function automatic logic [6:0] exp_ts(input int lo, input int hi);
    logic [3:0] nib;
    logic [2:0] base;
    nib  = (lo == 0) ? 4'h3 : (lo == 1) ? 4'h5 : 4'h9;
    base = (lo == 0) ? 3'h0 : (lo == 1) ? 3'h1 : 3'h4;
    return {nib, base + 3'(hi)};
  endfunction : exp_ts

  // One address word; exp is {memory hit, sensor hit}
  task automatic send(input logic [6:0] a, input logic rw, input logic [1:0] exp);
    int i;
    logic [1:0] hit;
    hit = 2'b00;
    chk({7'h00, req_ready_o}, 8'h01);
    req_valid_i = 1'b1;
    req_addr_i = a;
    req_rw_i = rw;
    for (i = 0; i < 300; i++) begin
      tick(1);
      req_valid_i = 1'b0;
      hit = hit | {memory_hit_o === 1'b1, sensor_hit_o === 1'b1};
      if (done_o === 1'b1) break;
    end
    if (i == 300) begin
      chk(8'h00, 8'h01);
      give_verdict();
    end
    chk({6'h00, hit}, {6'h00, exp});
    chk({6'h00, acked_o, refused_o}, {6'h00, |exp, a[6:3] == NIB_RSVD});
    if (|exp) chk({7'h00, hit_rw_o}, {7'h00, rw});
    tick(1);
  endtask : send

  task automatic conv();
    conv_start_i = 1'b1;
    tick(1);
    conv_start_i = 1'b0;
    tick(5);
  endtask : conv

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_memory();
    for (int s = 0; s < 8; s++) begin
      memory_addr_select_i = 3'(s);
      tick(6);
      chk({1'b0, memory_addr_o}, {1'b0, NIB_MEM, 3'(s)});
      send({NIB_MEM, 3'(s)}, s[0], 2'b10);
      send({NIB_MEM, 3'(s) ^ 3'h4}, s[1], 2'b00);
    end
    memory_addr_select_conn_i = 3'h5;
    tick(6);
    chk({1'b0, memory_addr_o}, {1'b0, NIB_MEM, 3'h5});
    send({NIB_MEM, 3'h5}, 1'b1, 2'b10);
  endtask : t_memory

  task automatic t_sensor();
    logic [6:0] ea;
    for (int lo = 0; lo < 3; lo++) begin
      for (int hi = 0; hi < 3; hi++) begin
        sensor_addr_strap_lo_i = 2'(lo);
        sensor_addr_strap_hi_i = 2'(hi);
        tick(4);
        conv();
        ea = exp_ts(lo, hi);
        chk({1'b0, sensor_addr_o}, {1'b0, ea});
        send(ea, hi[0], 2'b01);
        send(ea ^ 7'h01, lo[0], 2'b00);
        send(ea ^ 7'h40, 1'b0, 2'b00);
      end
    end
  endtask : t_sensor

  // Straps move without a conversion start: held address stays; a
  // start inside a frame waits for its end; code 3 reads as floating
  task automatic t_latch();
    sensor_addr_strap_lo_i = 2'h0;
    sensor_addr_strap_hi_i = 2'h0;
    tick(6);
    chk({1'b0, sensor_addr_o}, {1'b0, exp_ts(2, 2)});
    send(exp_ts(2, 2), 1'b0, 2'b01);
    conv();
    chk({1'b0, sensor_addr_o}, {1'b0, exp_ts(0, 0)});
    sensor_addr_strap_lo_i = 2'h1;
    sensor_addr_strap_hi_i = 2'h2;
    tick(4);
    fork
      send(exp_ts(0, 0), 1'b1, 2'b01);
      begin
        tick(20);
        conv_start_i = 1'b1;
        tick(1);
        conv_start_i = 1'b0;
      end
    join
    tick(5);
    chk({1'b0, sensor_addr_o}, {1'b0, exp_ts(1, 2)});
    sensor_addr_strap_lo_i = 2'h3;
    sensor_addr_strap_hi_i = 2'h3;
    tick(4);
    conv();
    chk({1'b0, sensor_addr_o}, {1'b0, exp_ts(1, 1)});
  endtask : t_latch

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    tick(20);
    nrst_i = 1'b1;
    tick(3);
    chk({1'b0, sensor_addr_o}, {1'b0, exp_ts(0, 0)});
    chk({1'b0, memory_addr_o}, {1'b0, NIB_MEM, 3'h5});
    t_memory();
    t_sensor();
    t_latch();
    send({NIB_RSVD, 3'h5}, 1'b0, 2'b00);
    give_verdict();
  end
endmodule : smbus_slave_address_decode_tb
